// File: afe_consts.vh
// Register map, field positions and reset values of the analog front end bank.
`ifndef AFE_CONSTS_VH
`define AFE_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define AFE_ADDR_REF_CTRL   8'h00
`define AFE_ADDR_REF_TRIM   8'h04
`define AFE_ADDR_DAC_MODE   8'h08
`define AFE_ADDR_DAC_LOW    8'h0c
`define AFE_ADDR_DAC_HIGH   8'h10
`define AFE_ADDR_AMP1_CTRL  8'h14
`define AFE_ADDR_AMP2_CTRL  8'h18
`define AFE_ADDR_GAIN_SW    8'h1c
`define AFE_ADDR_DAC_CODE   8'h20

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define AFE_REF_EN_BIT      4
`define AFE_REF_CTRL_MASK   8'h13
`define AFE_DAC_MODE_MASK   8'h03
`define AFE_DAC_LOW_MASK    8'hf0
`define AFE_GAIN_SW_MASK    8'h0f
`define AFE_AMP_MODE_BIT    7
`define AFE_AMP_REF_BIT     6
`define AFE_AMP_EN_BIT      5

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define AFE_RST_BYTE        8'h00
`define AFE_DAC_REF_AVDD    2'h2
`define AFE_DAC_REF_FLOAT   2'h3
`define AFE_DAC_OFF_HIZ     2'h0
`define AFE_DAC_OFF_GND     2'h2

`endif

// File: afe_amp_switch.v
// Switch decode for one operational amplifier.
`timescale 1ns/100ps

module afe_amp_switch (
   // Amplifier control bits
   input  wire       amp_cal_mode,
   input  wire       amp_cal_ref_select,
   // Mode switches: first, second, third
   output reg  [2:0] mode_switches
);

   always @* begin
      if (!amp_cal_mode) begin
         mode_switches = 3'h3;
      end else if (!amp_cal_ref_select) begin
         mode_switches = 3'h6;
      end else begin
         mode_switches = 3'h5;
      end
   end

endmodule // afe_amp_switch

// File: afe_ctrl_regs.v
// APB register bank steering the analog front end.
//
// How it works
// - Reference control bit 4 enables the reference generator, reset low.
// - Reference select 00/01 internal, 10 analog supply, 11 floating.
// - Eight-bit trim register, reset zero, drives reference fine tune.
// - DAC mode 00 off high-Z, 01/11 on, 10 off grounded.
// - DAC code is high byte then low register bits 7 to 4.
// - Unimplemented bits ignore writes and read back zero.
// - Amplifier control bit 7 selects offset calibration mode, reset low.
// - Bit 6 picks calibration reference; calibration only when set.
// - Bit 5 enables the amplifier, reset low.
// - Bits 4 to 0 are the five-bit offset trim, reset zero.
// - Switch decode per amplifier follows mode and reference bits.
// - Gain switch bit 3 ties the ground-return pin to ground.
// - Gain switch bits 2 to 0 join sense pins to output.
`timescale 1ns/100ps
`include "afe_consts.vh"

module afe_ctrl_regs (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Reference generator
   output wire        ref_gen_enable,
   output wire [7:0]  ref_trim,
   output wire [1:0]  dac_ref_select,
   output wire        dac_ref_internal,
   output wire        dac_ref_avdd,
   // DAC
   output wire [1:0]  dac_output_mode,
   output wire        dac_enable,
   output wire        dac_out_ground,
   output wire        dac_out_hiz,
   output wire [11:0] dac_code,
   // Amplifier one
   output wire        amp1_enable,
   output wire        amp1_cal_active,
   output wire [4:0]  amp1_offset_trim,
   output wire [2:0]  amp_one_mode_switches,
   // Amplifier two
   output wire        amp2_enable,
   output wire        amp2_cal_active,
   output wire [4:0]  amp2_offset_trim,
   output wire [2:0]  amp_two_mode_switches,
   // Gain switches
   output wire        ground_return_switch,
   output wire        sense2_feedback_switch,
   output wire        sense1_feedback_switch,
   output wire        sense0_feedback_switch
);

   // -------------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------------
   reg  [7:0]  ref_ctrl_r;
   reg  [7:0]  ref_trim_r;
   reg  [7:0]  dac_mode_r;
   reg  [7:0]  dac_low_r;
   reg  [7:0]  dac_high_r;
   reg  [7:0]  amp1_ctrl_r;
   reg  [7:0]  amp2_ctrl_r;
   reg  [7:0]  gain_sw_r;
   reg  [11:0] dac_code_r;

   wire        wr_en;
   wire        known;

   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `AFE_ADDR_REF_CTRL, `AFE_ADDR_REF_TRIM, `AFE_ADDR_DAC_MODE,
            `AFE_ADDR_DAC_LOW, `AFE_ADDR_DAC_HIGH, `AFE_ADDR_AMP1_CTRL,
            `AFE_ADDR_AMP2_CTRL, `AFE_ADDR_GAIN_SW,
            `AFE_ADDR_DAC_CODE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------------
   // Every access completes in its first access cycle; unmapped targets and
   // writes to the read-only code register answer with an error and change nothing.
   assign pready  = 1'b1;
   assign known   = is_mapped(paddr);
   assign pslverr = psel & penable &
                    (~known | (pwrite & (paddr == `AFE_ADDR_DAC_CODE)));
   assign wr_en   = psel & penable & pwrite & ~pslverr;

   // -------------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_ctrl_r  <= `AFE_RST_BYTE;
         ref_trim_r  <= `AFE_RST_BYTE;
         dac_mode_r  <= `AFE_RST_BYTE;
         dac_low_r   <= `AFE_RST_BYTE;
         dac_high_r  <= `AFE_RST_BYTE;
         amp1_ctrl_r <= `AFE_RST_BYTE;
         amp2_ctrl_r <= `AFE_RST_BYTE;
         gain_sw_r   <= `AFE_RST_BYTE;
         dac_code_r  <= 12'h000;
      end else if (wr_en) begin
         case (paddr)
            `AFE_ADDR_REF_CTRL: begin
               ref_ctrl_r <= pwdata[7:0] & `AFE_REF_CTRL_MASK;
            end
            `AFE_ADDR_REF_TRIM: begin
               ref_trim_r <= pwdata[7:0];
            end
            `AFE_ADDR_DAC_MODE: begin
               dac_mode_r <= pwdata[7:0] & `AFE_DAC_MODE_MASK;
            end
            `AFE_ADDR_DAC_LOW: begin
               // Held in the shadow only; the converter sees it later.
               dac_low_r <= pwdata[7:0] & `AFE_DAC_LOW_MASK;
            end
            `AFE_ADDR_DAC_HIGH: begin
               dac_high_r <= pwdata[7:0];
               dac_code_r <= {pwdata[7:0], dac_low_r[7:4]};
            end
            `AFE_ADDR_AMP1_CTRL: begin
               amp1_ctrl_r <= pwdata[7:0];
            end
            `AFE_ADDR_AMP2_CTRL: begin
               amp2_ctrl_r <= pwdata[7:0];
            end
            `AFE_ADDR_GAIN_SW: begin
               gain_sw_r <= pwdata[7:0] & `AFE_GAIN_SW_MASK;
            end
            default: begin
               gain_sw_r <= gain_sw_r;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   // Read data is registered during the setup cycle so it is stable
   // for the whole access phase.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `AFE_ADDR_REF_CTRL:  prdata <= {24'h00_0000, ref_ctrl_r};
            `AFE_ADDR_REF_TRIM:  prdata <= {24'h00_0000, ref_trim_r};
            `AFE_ADDR_DAC_MODE:  prdata <= {24'h00_0000, dac_mode_r};
            `AFE_ADDR_DAC_LOW:   prdata <= {24'h00_0000, dac_low_r};
            `AFE_ADDR_DAC_HIGH:  prdata <= {24'h00_0000, dac_high_r};
            `AFE_ADDR_AMP1_CTRL: prdata <= {24'h00_0000, amp1_ctrl_r};
            `AFE_ADDR_AMP2_CTRL: prdata <= {24'h00_0000, amp2_ctrl_r};
            `AFE_ADDR_GAIN_SW:   prdata <= {24'h00_0000, gain_sw_r};
            `AFE_ADDR_DAC_CODE:  prdata <= {20'h0_0000, dac_code_r};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Reference and DAC controls
   // -------------------------------------------------------------------------
   assign ref_gen_enable   = ref_ctrl_r[`AFE_REF_EN_BIT];
   assign ref_trim         = ref_trim_r;
   assign dac_ref_select   = ref_ctrl_r[1:0];
   assign dac_ref_internal = ~ref_ctrl_r[1];
   assign dac_ref_avdd     = (ref_ctrl_r[1:0] == `AFE_DAC_REF_AVDD);
   assign dac_output_mode  = dac_mode_r[1:0];
   assign dac_enable       = dac_mode_r[0];
   assign dac_out_ground   = (dac_mode_r[1:0] == `AFE_DAC_OFF_GND);
   assign dac_out_hiz      = (dac_mode_r[1:0] == `AFE_DAC_OFF_HIZ);
   assign dac_code         = dac_code_r;

   // -------------------------------------------------------------------------
   // Amplifiers
   // -------------------------------------------------------------------------
   assign amp1_enable      = amp1_ctrl_r[`AFE_AMP_EN_BIT];
   assign amp2_enable      = amp2_ctrl_r[`AFE_AMP_EN_BIT];
   // Calibration only runs against the DAC reference.
   assign amp1_cal_active  = amp1_ctrl_r[`AFE_AMP_MODE_BIT] &
                             amp1_ctrl_r[`AFE_AMP_REF_BIT];
   assign amp2_cal_active  = amp2_ctrl_r[`AFE_AMP_MODE_BIT] &
                             amp2_ctrl_r[`AFE_AMP_REF_BIT];
   assign amp1_offset_trim = amp1_ctrl_r[4:0];
   assign amp2_offset_trim = amp2_ctrl_r[4:0];

   afe_amp_switch u_sw1 (
      .amp_cal_mode       (amp1_ctrl_r[`AFE_AMP_MODE_BIT]),
      .amp_cal_ref_select (amp1_ctrl_r[`AFE_AMP_REF_BIT]),
      .mode_switches      (amp_one_mode_switches)
   );

   afe_amp_switch u_sw2 (
      .amp_cal_mode       (amp2_ctrl_r[`AFE_AMP_MODE_BIT]),
      .amp_cal_ref_select (amp2_ctrl_r[`AFE_AMP_REF_BIT]),
      .mode_switches      (amp_two_mode_switches)
   );

   // -------------------------------------------------------------------------
   // Gain switches
   // -------------------------------------------------------------------------
   assign ground_return_switch   = gain_sw_r[3];
   assign sense2_feedback_switch = gain_sw_r[2];
   assign sense1_feedback_switch = gain_sw_r[1];
   assign sense0_feedback_switch = gain_sw_r[0];

endmodule // afe_ctrl_regs

// File: afe_regs_checker.sv
// Assertion checker for the analog front end register bank.
`timescale 1ns/100ps
module afe_regs_checker (
   // Clock, reset and bus
   input wire        clk,
   input wire        rst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire        pslverr,
   // Watched outputs
   input wire        ref_gen_enable,
   input wire [7:0]  ref_trim,
   input wire [1:0]  dac_ref_select,
   input wire        dac_ref_internal,
   input wire        dac_ref_avdd,
   input wire [1:0]  dac_output_mode,
   input wire        dac_out_ground,
   input wire        dac_out_hiz,
   input wire [11:0] dac_code,
   input wire [4:0]  amp1_offset_trim,
   input wire        amp1_cal_active,
   input wire [2:0]  amp_one_mode_switches,
   input wire        ground_return_switch
);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   wire wr = psel && penable && pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_REF_EN: assert property (
      wr && paddr == 8'h00 |=> ref_gen_enable == $past(pwdata[4]))
      else $error("reference enable wrong");
   AST_REF_TRIM: assert property (
      wr && paddr == 8'h04 |=> ref_trim == $past(pwdata[7:0]))
      else $error("reference trim wrong");
   AST_DAC_REF: assert property (
      dac_ref_internal == !dac_ref_select[1] &&
      dac_ref_avdd == (dac_ref_select == 2'h2))
      else $error("dac reference decode wrong");
   AST_DAC_MODE: assert property (
      dac_out_hiz == (dac_output_mode == 2'h0) &&
      dac_out_ground == (dac_output_mode == 2'h2))
      else $error("dac mode decode wrong");
   AST_DAC_HOLD: assert property (
      !(wr && paddr == 8'h10) |=> $stable(dac_code))
      else $error("dac code moved without high write");
   AST_DAC_CODE: assert property (
      wr && paddr == 8'h10 |=> dac_code[11:4] == $past(pwdata[7:0]))
      else $error("dac code high part wrong");
   AST_AMP_TRIM: assert property (
      wr && paddr == 8'h14 |=> amp1_offset_trim == $past(pwdata[4:0]))
      else $error("offset trim wrong");
   AST_AMP_SW: assert property (
      amp1_cal_active |-> amp_one_mode_switches == 3'h5)
      else $error("calibration switches wrong");
   AST_GND_SW: assert property (
      wr && paddr == 8'h1c |=> ground_return_switch == $past(pwdata[3]))
      else $error("ground switch wrong");
   AST_BAD_ADDR: assert property (
      psel && penable && paddr > 8'h20 |-> pslverr)
      else $error("unmapped access not refused");
   COV_DAC: cover property (wr && paddr == 8'h10);
   COV_CAL: cover property (amp1_cal_active);
   COV_ERR: cover property (psel && penable && pslverr);
endmodule // afe_regs_checker

bind afe_ctrl_regs afe_regs_checker u_chk (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pslverr(pslverr), .ref_gen_enable(ref_gen_enable),
   .ref_trim(ref_trim), .dac_ref_select(dac_ref_select),
   .dac_ref_internal(dac_ref_internal), .dac_ref_avdd(dac_ref_avdd),
   .dac_output_mode(dac_output_mode), .dac_out_ground(dac_out_ground),
   .dac_out_hiz(dac_out_hiz), .dac_code(dac_code),
   .amp1_offset_trim(amp1_offset_trim), .amp1_cal_active(amp1_cal_active),
   .amp_one_mode_switches(amp_one_mode_switches),
   .ground_return_switch(ground_return_switch));

// File: tb.sv
// Self-checking bench for the analog front end register bank.
`timescale 1ns/100ps
module tb;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err;
   logic        rg_en, r_int, r_avdd, d_en, d_gnd, d_hiz;
   logic        e1, e2, c1, c2, g3, g2, g1, g0;
   logic [7:0]  r_trim;
   logic [1:0]  r_sel, d_mode;
   logic [11:0] dac_code;
   logic [4:0]  t1, t2;
   logic [2:0]  sw1, sw2, es;
   int          errors = 0, num_checks = 0, i, n;
   // Rows are address, write data and expected read-back.
   localparam logic [23:0] ROWS [8] = '{24'h00ff13, 24'h04a5a5,
      24'h08ff03, 24'h0cfff0, 24'h105a5a, 24'h14ffff, 24'h183c3c,
      24'h1cff0f};
   always #5 clk = ~clk;
   afe_ctrl_regs u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ref_gen_enable(rg_en), .ref_trim(r_trim), .dac_ref_select(r_sel),
      .dac_ref_internal(r_int), .dac_ref_avdd(r_avdd),
      .dac_output_mode(d_mode), .dac_enable(d_en), .dac_out_ground(d_gnd),
      .dac_out_hiz(d_hiz), .dac_code(dac_code), .amp1_enable(e1),
      .amp1_cal_active(c1), .amp1_offset_trim(t1),
      .amp_one_mode_switches(sw1), .amp2_enable(e2), .amp2_cal_active(c2),
      .amp2_offset_trim(t2), .amp_two_mode_switches(sw2),
      .ground_return_switch(g3), .sense2_feedback_switch(g2),
      .sense1_feedback_switch(g1), .sense0_feedback_switch(g0));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         errors++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wt;
      @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      for (i = 0; i < 8; i++) begin
         apb(0, 8'(i * 4), 0);
         chk("reset value", rd, 0);
      end
      chk("reset sw", {d_hiz, r_int, sw2, sw1}, 8'hdb);
      for (i = 0; i < 8; i++) begin
         apb(1, ROWS[i][23:16], {24'h0, ROWS[i][15:8]});
         apb(0, ROWS[i][23:16], 0);
         chk("read back", rd, {24'h0, ROWS[i][7:0]});
      end
      apb(1, 8'h0c, 8'h30);
      wt();
      chk("dac held", dac_code, 12'h5af);
      apb(1, 8'h10, 8'hc7);
      wt();
      chk("dac code", dac_code, 12'hc73);
      for (i = 0; i < 4; i++) begin
         apb(1, 8'h08, i);
         apb(1, 8'h00, i);
         wt();
         chk("dac mode", {d_hiz, d_gnd, d_en}, {i == 0, i == 2, i[0]});
         chk("dac ref", {r_avdd, r_int}, {i == 2, i < 2});
         chk("ref off", rg_en, 0);
         es = i[1] ? (i[0] ? 3'h5 : 3'h6) : 3'h3;
         apb(1, 8'h14, 8'(i * 64) | 8'h35);
         apb(1, 8'h18, 8'(i * 64) | 8'h2a);
         wt();
         chk("switches", {sw2, sw1}, {es, es});
         chk("cal", {c2, c1}, {i == 3, i == 3});
         chk("amp", {e2, t2, e1, t1}, 12'hab5);
      end
      apb(1, 8'h1c, 8'h1a);
      wt();
      chk("gain sw", {g3, g2, g1, g0}, 4'ha);
      apb(0, 8'h24, 0);
      chk("unmapped err", err, 1);
      chk("unmapped rd", rd, 0);
      apb(1, 8'h20, 32'hffff);
      chk("readonly", err, 1);
      // Offset calibration sweep as software runs it on amplifier one.
      for (i = 0; i < 3; i++) begin
         apb(1, 8'h14, 8'hc0 | i);
      end
      wt();
      chk("cal up", {c1, t1}, 6'h22);
      for (i = 31; i > 28; i--) begin
         apb(1, 8'h14, 8'hc0 | i);
      end
      wt();
      chk("cal down", t1, 5'h1d);
      apb(1, 8'h14, 8'hc0 | ((2 + 29) / 2));
      wt();
      chk("cal average", {c1, t1}, 6'h2f);
      rst_n <= 0;
      wt();
      chk("reset again", {r_trim, dac_code, g3}, 0);
      wrap_up();
   end
endmodule // tb
